// file: rtl/monitor_status_pkg.sv
// constants for the monitor status register bank
package monitor_status_pkg;
  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 16;
  localparam logic [7:0] PROGRESS_ADDR = 8'h02;
  localparam logic [7:0] FAULT_ADDR = 8'h03;
  localparam logic [15:0] PROGRESS_RESET = 16'h0000;
  localparam logic [15:0] FAULT_RESET = 16'hFFFF;
  localparam int MUX_SEQ_LSB = 14;
  localparam int CUR_A_LSB = 10;
  localparam int CUR_B_LSB = 8;
  localparam int MUX_RUN_BIT = 1;
  localparam int FAULT_COUNT = 16;
  localparam logic [1:0] COUNTER_ZERO = 2'h0;
  localparam logic [1:0] COUNTER_STEP = 2'h1;
  localparam logic [7:0] MUX_CFG_FIRST = 8'h8C;
  localparam logic [7:0] MUX_CFG_LAST = 8'h9F;
endpackage

// file: rtl/wrap_counter.sv
// two-bit wrapping completion counter with synchronous clear
`timescale 1ns/10ps
`default_nettype none
module wrap_counter
  import monitor_status_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_clear,
  input wire logic i_step,
  // count
  output logic [1:0] o_count
);
  typedef struct packed {
    logic [1:0] count_r;
  } wrap_state_s;

  wrap_state_s st_r;
  wrap_state_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    // clear dominates: a completion in a disabled cycle does not count
    if (i_clear) begin
      st_nxt.count_r = COUNTER_ZERO;
    end else if (i_step) begin
      st_nxt.count_r = st_r.count_r + COUNTER_STEP;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_count = st_r.count_r;

  a_count_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_clear |=> o_count == COUNTER_ZERO) else $error("counter not cleared");
  a_count_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_clear && i_step) |=> o_count == $past(o_count) + COUNTER_STEP) else $error("counter did not advance");
  a_count_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_clear && !i_step) |=> $stable(o_count)) else $error("counter moved without cause");
endmodule
`default_nettype wire

// file: rtl/monitor_status_registers.sv
// conversion progress and supply fault status registers
`timescale 1ns/10ps
`default_nettype none
module monitor_status_registers
  import monitor_status_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register access port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [REG_ADDR_W-1:0] i_reg_addr,
  input wire logic [REG_DATA_W-1:0] i_reg_wdata,
  output logic [REG_DATA_W-1:0] o_reg_rdata,
  output logic o_reg_hit,
  // converter events
  input wire logic i_low_power,
  input wire logic i_mux_enable,
  input wire logic i_mux_sequence_done,
  input wire logic i_mux_sequence_running,
  input wire logic i_current_a_enable,
  input wire logic i_current_a_done,
  input wire logic i_current_b_enable,
  input wire logic i_current_b_done,
  // fault detector pulses, bit n drops flag n
  input wire logic [FAULT_COUNT-1:0] i_fault_event,
  // register contents
  output logic [REG_DATA_W-1:0] o_progress_status,
  output logic [REG_DATA_W-1:0] o_fault_flags
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic [FAULT_COUNT-1:0] fault_r;
    logic running_r;
    logic [REG_DATA_W-1:0] rdata_r;
    logic hit_r;
  } bank_state_s;

  bank_state_s st_r;
  bank_state_s st_nxt;

  logic [1:0] mux_sequence_counter;
  logic [1:0] current_a_conversion_counter;
  logic [1:0] current_b_conversion_counter;
  logic [REG_DATA_W-1:0] progress_word;
  logic fault_wr;

  // --------------------------------------------------------------
  // layout checks
  // --------------------------------------------------------------
  // the fault word is read back whole, so it must fill the data word
  if (FAULT_COUNT != REG_DATA_W) begin : g_bad_fault_width
    $error("fault flag count must equal the register width");
  end
  // a counter field or the running bit outside the word would be lost
  if (MUX_SEQ_LSB + 2 > REG_DATA_W || CUR_A_LSB + 2 > REG_DATA_W || CUR_B_LSB + 2 > REG_DATA_W) begin : g_bad_field
    $error("counter field outside the register word");
  end
  if (MUX_RUN_BIT >= REG_DATA_W) begin : g_bad_run_bit
    $error("running bit outside the register word");
  end

  // --------------------------------------------------------------
  // completion counters
  // --------------------------------------------------------------
  // sequence counter advance
  wrap_counter u_mux_seq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(!i_mux_enable || i_low_power),
    .i_step(i_mux_sequence_done),
    .o_count(mux_sequence_counter)
  );

  wrap_counter u_cur_a (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(!i_current_a_enable || i_low_power),
    .i_step(i_current_a_done),
    .o_count(current_a_conversion_counter)
  );

  wrap_counter u_cur_b (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(!i_current_b_enable || i_low_power),
    .i_step(i_current_b_done),
    .o_count(current_b_conversion_counter)
  );

  // --------------------------------------------------------------
  // register word assembly
  // --------------------------------------------------------------
  // unused positions zero
  always_comb begin
    progress_word = PROGRESS_RESET;
    progress_word[MUX_SEQ_LSB +: 2] = mux_sequence_counter;
    progress_word[CUR_A_LSB +: 2] = current_a_conversion_counter;
    progress_word[CUR_B_LSB +: 2] = current_b_conversion_counter;
    progress_word[MUX_RUN_BIT] = st_r.running_r;
  end

  // only the fault address takes writes
  assign fault_wr = i_reg_wr && (i_reg_addr == FAULT_ADDR);

  always_comb begin
    st_nxt = st_r;
    st_nxt.running_r = i_mux_sequence_running && i_mux_enable && !i_low_power;
    for (int i = 0; i < FAULT_COUNT; i++) begin
      // sticky flag, detection wins over a same-cycle restore
      if (i_fault_event[i]) begin
        st_nxt.fault_r[i] = 1'b0;
      end else if (fault_wr && i_reg_wdata[i]) begin
        st_nxt.fault_r[i] = 1'b1;
      end
    end
    st_nxt.hit_r = 1'b0;
    if (i_reg_rd) begin
      case (i_reg_addr)
        PROGRESS_ADDR: begin
          st_nxt.rdata_r = progress_word;
          st_nxt.hit_r = 1'b1;
        end
        FAULT_ADDR: begin
          st_nxt.rdata_r = st_r.fault_r;
          st_nxt.hit_r = 1'b1;
        end
        default: begin
          st_nxt.rdata_r = '0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r.fault_r <= FAULT_RESET;
      st_r.running_r <= 1'b0;
      st_r.rdata_r <= '0;
      st_r.hit_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_reg_rdata = st_r.rdata_r;
  assign o_reg_hit = st_r.hit_r;
  assign o_progress_status = progress_word;
  assign o_fault_flags = st_r.fault_r;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_progress_status[13:12] == 2'h0 && o_progress_status[7:2] == 6'h00 && !o_progress_status[0])
    else $error("reserved progress bits not zero");
  a_running_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_mux_sequence_running && i_mux_enable && !i_low_power) |=> o_progress_status[MUX_RUN_BIT])
    else $error("running bit not set");
  a_running_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_mux_enable |=> !o_progress_status[MUX_RUN_BIT]) else $error("running bit set while disabled");
  a_fault_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[15] |=> !o_fault_flags[15]) else $error("overvoltage flag did not drop");
  a_fault_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!o_fault_flags[4] && !(fault_wr && i_reg_wdata[4])) |=> !o_fault_flags[4])
    else $error("fault flag restored without write");
  a_fault_restore: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (fault_wr && i_reg_wdata[0] && !i_fault_event[0]) |=> o_fault_flags[0]) else $error("flag not restored");
  a_zero_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (fault_wr && i_reg_wdata == 16'h0000 && i_fault_event == 16'h0000) |=> $stable(o_fault_flags))
    else $error("zero write changed flags");
  a_read_fault: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr == FAULT_ADDR) |=> (o_reg_hit && o_reg_rdata == $past(o_fault_flags)))
    else $error("fault read wrong");
  a_read_progress: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr == PROGRESS_ADDR) |=> (o_reg_hit && o_reg_rdata == $past(o_progress_status)))
    else $error("progress read wrong");
  a_seq_lowpower: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_low_power |=> o_progress_status[15:14] == 2'h0) else $error("sequence counter not cleared");

  // --------------------------------------------------------------
  // per-flag fault drops
  // --------------------------------------------------------------
  // one check per flag for flags 14 to 0 (flag 15 is checked by a_fault_drop): a crossed event index shows up here, not in the loop
  a_drop_analog_uv: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[14] |=> !o_fault_flags[14])
    else $error("analog undervoltage flag did not drop");
  a_drop_io_ov: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[13] |=> !o_fault_flags[13])
    else $error("io overvoltage flag did not drop");
  a_drop_io_uv: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[12] |=> !o_fault_flags[12])
    else $error("io undervoltage flag did not drop");

  a_drop_dig_ov: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[11] |=> !o_fault_flags[11])
    else $error("digital overvoltage flag did not drop");
  a_drop_dig_uv: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[10] |=> !o_fault_flags[10])
    else $error("digital undervoltage flag did not drop");

  a_drop_analog_osc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[9] |=> !o_fault_flags[9])
    else $error("analog oscillation flag did not drop");
  a_drop_io_osc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[8] |=> !o_fault_flags[8])
    else $error("io oscillation flag did not drop");
  a_drop_dig_osc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[7] |=> !o_fault_flags[7])
    else $error("digital oscillation flag did not drop");

  a_drop_analog_temp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[6] |=> !o_fault_flags[6])
    else $error("analog overtemperature flag did not drop");
  a_drop_io_temp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[5] |=> !o_fault_flags[5])
    else $error("io overtemperature flag did not drop");
  a_drop_analog_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[4] |=> !o_fault_flags[4])
    else $error("analog current limit flag did not drop");

  a_drop_io_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[3] |=> !o_fault_flags[3])
    else $error("io current limit flag did not drop");
  a_drop_gnd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[2] |=> !o_fault_flags[2])
    else $error("first analog ground flag did not drop");
  a_drop_gnd_b: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[1] |=> !o_fault_flags[1])
    else $error("second analog ground flag did not drop");
  a_drop_dig_gnd: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fault_event[0] |=> !o_fault_flags[0])
    else $error("digital ground flag did not drop");

  // --------------------------------------------------------------
  // clears, refused writes and read timing
  // --------------------------------------------------------------
  a_seq_disable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_mux_enable |=> o_progress_status[15:14] == 2'h0)
    else $error("sequence counter not cleared on disable");
  a_cur_a_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_current_a_enable || i_low_power) |=> o_progress_status[11:10] == 2'h0)
    else $error("converter a counter not cleared");
  a_cur_b_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_current_b_enable || i_low_power) |=> o_progress_status[9:8] == 2'h0)
    else $error("converter b counter not cleared");
  a_running_lowpower: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_low_power |=> !o_progress_status[MUX_RUN_BIT])
    else $error("running bit set in low power");
  a_write_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr != FAULT_ADDR && i_fault_event == 16'h0000) |=> $stable(o_fault_flags))
    else $error("write to other address changed flags");
  a_read_unmapped: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr != PROGRESS_ADDR && i_reg_addr != FAULT_ADDR) |=> (!o_reg_hit && o_reg_rdata == '0))
    else $error("unmapped read answered");
  a_hit_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_reg_rd |=> !o_reg_hit)
    else $error("hit without a read");
  a_rdata_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
endmodule
`default_nettype wire

// file: test/status_host_model.sv
// host-side register access model for the status bank
`timescale 1ns/10ps
`default_nettype none
module status_host_model
  import monitor_status_pkg::*;
(
  // clock
  input wire logic i_clk,
  // register access port
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [REG_ADDR_W-1:0] o_reg_addr,
  output logic [REG_DATA_W-1:0] o_reg_wdata
);
  initial begin
    o_reg_wr = 1'h0;
    o_reg_rd = 1'h0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 16'h0000;
  end
  // mux config range is never addressed
  // restore is done by writing ones
  task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] data);
    @(posedge i_clk);
    o_reg_wr <= wr;
    o_reg_rd <= !wr;
    o_reg_addr <= addr;
    o_reg_wdata <= data;
    @(posedge i_clk);
    o_reg_wr <= 1'h0;
    o_reg_rd <= 1'h0;
    // released data flips so stale values never look valid
    o_reg_wdata <= ~data;
  endtask
endmodule
`default_nettype wire

// file: test/monitor_status_registers_tb_top.sv
// self-checking bench for the status register bank
`timescale 1ns/10ps
`default_nettype none
module monitor_status_registers_tb_top;
  import monitor_status_pkg::*;
  logic i_clk = 1'h0;
  logic i_rst_n = 1'h0;
  logic lp = 1'h0, me = 1'h0, md = 1'h0, mr = 1'h0, ae = 1'h0, ad = 1'h0, be = 1'h0, bd = 1'h0;
  logic [15:0] ev = 16'h0000;
  wire logic wr, rd;
  wire logic [7:0] addr;
  wire logic [15:0] wdata, rdata, prog, flags;
  wire logic hit;
  logic [31:0] seed = 32'h1573;
  int n_mismatch = 0, comparisons = 0, ms = 0, ma = 0, mb = 0, mrun = 0;
  logic [15:0] mflags = 16'hFFFF, mrdata = 16'h0000;
  logic mhit = 1'h0;
  logic [7:0] atab [3] = '{8'h02, 8'h03, 8'h05};
  initial forever #25 i_clk = !i_clk;
  status_host_model u_status_host_model (.i_clk(i_clk), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr),
    .o_reg_wdata(wdata));
  monitor_status_registers u_monitor_status_registers (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_hit(hit),
    .i_low_power(lp), .i_mux_enable(me), .i_mux_sequence_done(md), .i_mux_sequence_running(mr),
    .i_current_a_enable(ae), .i_current_a_done(ad), .i_current_b_enable(be), .i_current_b_done(bd),
    .i_fault_event(ev), .o_progress_status(prog), .o_fault_flags(flags));
  function automatic logic [31:0] rnd();
    seed = {1'h0, seed[31:1]} ^ (seed[0] ? 32'h80200003 : 32'h00000000);
    return seed;
  endfunction
  function automatic logic [15:0] mprog();
    return {2'(ms), 2'h0, 2'(ma), 2'(mb), 6'h00, 1'(mrun), 1'h0};
  endfunction
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t hit got %b expected %b", $time, got, exp);
    end
  endtask
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ms = 0;
      ma = 0;
      mb = 0;
      mrun = 0;
      mflags = 16'hFFFF;
      mrdata = 16'h0000;
      mhit = 1'h0;
    end else begin
      if (rd) mrdata = (addr == 8'h02) ? mprog() : (addr == 8'h03) ? mflags : 16'h0000;
      mhit = rd && (addr == 8'h02 || addr == 8'h03);
      // fault event wins over a same-cycle restore
      mflags = (mflags | ((wr && addr == 8'h03) ? wdata : 16'h0000)) & ~ev;
      ms = (!me || lp) ? 0 : (ms + int'(md)) % 4;
      ma = (!ae || lp) ? 0 : (ma + int'(ad)) % 4;
      mb = (!be || lp) ? 0 : (mb + int'(bd)) % 4;
      mrun = int'(mr && me && !lp);
    end
  end
  always @(negedge i_clk) begin
    cmp_word(prog, mprog());
    cmp_word(flags, mflags);
    cmp_word(rdata, mrdata);
    cmp_bit(hit, mhit);
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // random events; enables mostly on so counters wrap
  task automatic run(input int n);
    logic [31:0] r;
    logic [31:0] r1;
    logic [31:0] r2;
    logic [31:0] r3;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      r = rnd();
      r1 = rnd();
      r2 = rnd();
      r3 = rnd();
      {me, ae, be} <= {|r[2:0], |r[5:3], |r[8:6]};
      lp <= &r[12:9];
      {md, mr, ad, bd} <= r[16:13];
      ev <= r[31:16] & r1[15:0] & r2[15:0] & r3[15:0];
    end
  endtask
  task automatic host(input int n);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      // a quarter of the writes carry zeros, which must change nothing
      u_status_host_model.access(r[0], atab[r[2:1] % 3], (r[4:3] == 2'h0) ? 16'h0000 : r[31:16]);
    end
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'h1;
    fork
      run(600);
      host(250);
    join
    // second reset in mid-run
    i_rst_n <= 1'h0;
    // inputs idle through reset so no stale event lands on the release edge
    {lp, me, md, mr, ae, ad, be, bd} <= 8'h00;
    ev <= 16'h0000;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'h1;
    fork
      run(200);
      host(80);
    join
    final_report();
  end
  initial begin
    #(2000 * 50);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
